// ===== rtl/nvsq_pkg.sv
// constants shared by the profile save sequencer, its buffer and its serial writer
// assumes one 20 MHz clock and an 8-bit register port from the control-port logic
package nvsq_pkg;
    // register port addresses
    localparam logic [15:0] ADDR_BUF_BASE        = 16'h0A00; // first buffer slot
    localparam logic [15:0] ADDR_STATUS          = 16'h0B00; // transfer active, read only
    localparam logic [15:0] ADDR_ERROR           = 16'h0B01; // transfer error, read only
    localparam logic [15:0] ADDR_WR_ENABLE       = 16'h0B02; // memory write enable
    localparam logic [15:0] ADDR_SAVE_REQ        = 16'h0B03; // nvm_save_request
    localparam logic [15:0] ADDR_STROBE          = 16'h0232; // transfer strobe, self clearing
    // buffer slots of the example layout
    localparam logic [15:0] GROUP1_BYTE_COUNT    = 16'h0A00;
    localparam logic [15:0] GROUP1_ADDR_HIGH     = 16'h0A01;
    localparam logic [15:0] GROUP1_ADDR_LOW      = 16'h0A02;
    localparam logic [15:0] GROUP2_BYTE_COUNT    = 16'h0A03;
    localparam logic [15:0] GROUP2_ADDR_HIGH     = 16'h0A04;
    localparam logic [15:0] GROUP2_ADDR_LOW      = 16'h0A05;
    localparam logic [15:0] GROUP3_BYTE_COUNT    = 16'h0A06;
    localparam logic [15:0] GROUP3_ADDR_HIGH     = 16'h0A07;
    localparam logic [15:0] GROUP3_ADDR_LOW      = 16'h0A08;
    localparam logic [15:0] STROBE_OPCODE_SLOT   = 16'h0A09;
    localparam logic [15:0] END_OPCODE_SLOT      = 16'h0A0A;
    // field positions
    localparam int          BIT_FLAG             = 0;  // bit 0 of every control byte
    localparam int          BIT_CODE             = 7;  // set for operational codes
    // buffer geometry and operational codes
    localparam int          BUF_BYTES            = 23;
    localparam logic [7:0]  OPC_STROBE           = 8'h80;
    localparam logic [7:0]  OPC_PSEUDO_END       = 8'hFE;
    localparam logic [7:0]  OPC_END              = 8'hFF;
    // values after reset
    localparam logic [7:0]  BUF_RESET_VAL        = 8'hFF; // empty profile: end code only
    // memory geometry and serial framing
    localparam int          NVM_AW               = 9;  // 512 bytes
    localparam int          FRAME_BITS           = NVM_AW + 8;
    localparam int          SCK_HALF_CYCLES      = 1;  // clock cycles per serial half bit
endpackage

// ===== rtl/nvsq_strm_if.sv
// valid/ready word carrier between the sequencer, its buffer and the serial writer
// assumes a single clock shared by both ends
`timescale 1ns/10ps
interface nvsq_strm_if #(
    parameter int W = 17
);
    logic         valid; // word offered
    logic         ready; // word accepted when both high
    logic [W-1:0] data;  // memory address and byte
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== rtl/nvsq_buf2.sv
// two-entry word buffer; a stall downstream loses no word
// assumes same clock on both sides; async active-low reset
`timescale 1ns/10ps
module nvsq_buf2 #(
    parameter int W = 17
) (
    // clock and reset
    input  wire logic   clk_i,
    input  wire logic   rstn_i,
    // filling and draining sides
    nvsq_strm_if.snk    in_s,
    nvsq_strm_if.src    out_s,
    // state
    output logic        empty_o
);
    logic [W-1:0] mem_reg [2];   // storage, two entries
    logic         wr_ptr_reg;    // next slot to fill
    logic         rd_ptr_reg;    // next slot to drain
    logic [1:0]   cnt_reg;       // words held
    logic         push;
    logic         pop;

    // honest full and empty
    assign in_s.ready  = (cnt_reg != 2'h2);
    assign out_s.valid = (cnt_reg != 2'h0);
    assign out_s.data  = mem_reg[rd_ptr_reg];
    assign empty_o     = (cnt_reg == 2'h0);
    assign push        = in_s.valid & in_s.ready;
    assign pop         = out_s.valid & out_s.ready;

    // storage and pointers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            cnt_reg    <= 2'h0;
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_s.data;
                wr_ptr_reg          <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ===== rtl/nvsq_nvm_wr.sv
// serial master that writes one byte per frame into the configuration memory
// frame: select high, address then data, msb first, data changes while clock low
`timescale 1ns/10ps
module nvsq_nvm_wr (
    // clock and reset
    input  wire logic   clk_i,
    input  wire logic   rstn_i,
    // words to write
    nvsq_strm_if.snk    in_s,
    // serial pins
    output logic        cs_o,
    output logic        sck_o,
    output logic        sdo_o,
    output logic        busy_o
);
    logic [nvsq_pkg::FRAME_BITS-1:0] sh_reg;   // bits left to send
    logic [4:0]                      bits_reg; // bits remaining in frame
    logic                            cs_reg;   // frame open
    logic                            sck_reg;  // serial clock level

    // one word is taken only between frames
    assign in_s.ready = ~cs_reg;
    assign cs_o       = cs_reg;
    assign sck_o      = sck_reg;
    assign sdo_o      = sh_reg[nvsq_pkg::FRAME_BITS-1];
    assign busy_o     = cs_reg;

    // shift engine: two clock cycles per bit
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sh_reg   <= '0;
            bits_reg <= 5'h00;
            cs_reg   <= 1'b0;
            sck_reg  <= 1'b0;
        end else if (!cs_reg) begin
            if (in_s.valid) begin
                sh_reg   <= in_s.data;
                bits_reg <= 5'(nvsq_pkg::FRAME_BITS);
                cs_reg   <= 1'b1;
            end
        end else if (!sck_reg) begin
            sck_reg <= 1'b1;                    // memory samples on rising edge
        end else begin
            sck_reg  <= 1'b0;
            sh_reg   <= {sh_reg[nvsq_pkg::FRAME_BITS-2:0], 1'b0};
            bits_reg <= bits_reg - 5'h01;
            if (bits_reg == 5'h01) begin
                cs_reg <= 1'b0;                 // frame ends after last bit
            end
        end
    end
endmodule

// ===== rtl/nvsq_top.sv
// profile save sequencer: walks the buffer segment and streams bytes to the memory
// assumes the register port and the register bank read port share MCLK_I
`timescale 1ns/10ps

// Notes on behaviour
// R1: buffer holds 23 bytes, seven groups max
// R2: byte 0xFE is the pseudo end code
// R3: pseudo end stops, clears request, frees port
// R4: host re-arms request then writes strobe
// R5: resumed save continues at held memory address
// R6: same register may be saved many times
// R7: group byte one: bit7 zero, count below
// R8: next two bytes: address high then low
// R9: byte 0x80 is the transfer strobe code
// R10: writes to unmapped addresses are ignored
// R11: byte 0xFF ends the transfer
// R12: active status set at start, cleared at end
// R13: strobe updates active bank from buffer bank; a strobe that starts a save gives no update here
// R14: host holds writes until request clears
module nvsq_top #(
    parameter int BUF_N = nvsq_pkg::BUF_BYTES,   // buffer segment size
    parameter int AW    = nvsq_pkg::NVM_AW       // memory address width
) (
    // clock and reset
    input  wire logic        MCLK_I,
    input  wire logic        RSTN_I,
    // register port from the serial control port
    input  wire logic        REG_WR_I,
    input  wire logic [15:0] REG_ADDR_I,
    input  wire logic [7:0]  REG_WDATA_I,
    output logic      [7:0]  REG_RDATA_O,
    output logic             HOST_PORT_EN_O,
    // read port into the device register bank
    output logic      [15:0] CFG_ADDR_O,
    input  wire logic [7:0]  CFG_DATA_I,
    output logic             UPDATE_O,
    // status
    output logic             STATUS_ACTIVE_O,
    // memory serial pins
    output logic             NVM_CS_O,
    output logic             NVM_SCK_O,
    output logic             NVM_SDO_O
);
    typedef enum logic [2:0] {
        S_IDLE,   // waiting for strobe
        S_CMD,    // decode buffer byte
        S_AHI,    // address high byte
        S_ALO,    // address low byte
        S_RD,     // present register address
        S_DAT,    // push register value
        S_DRAIN   // let the writer empty
    } nvsq_state_t;

    localparam int FW = AW + 8;  // word carried to the writer

    if (BUF_N < 3 || BUF_N > 31) begin : g_chk_buf
        $error("buffer size out of range");
    end
    if (AW != nvsq_pkg::NVM_AW) begin : g_chk_aw
        $error("memory address width must match the writer");
    end

    // true when an address falls in the buffer segment
    function automatic logic is_buf(input logic [15:0] a);
        is_buf = (a >= nvsq_pkg::ADDR_BUF_BASE) &&
                 (a < nvsq_pkg::ADDR_BUF_BASE + 16'(BUF_N));
    endfunction

    // buffer slot index of an address
    function automatic logic [4:0] buf_idx(input logic [15:0] a);
        logic [15:0] d;
        d = a - nvsq_pkg::ADDR_BUF_BASE;
        buf_idx = d[4:0];
    endfunction

    nvsq_state_t     state_reg;       // sequencer state
    logic [7:0]      buf_mem [BUF_N]; // buffer segment storage
    logic [4:0]      ptr_reg;         // buffer byte being walked
    logic [6:0]      cnt_reg;         // group bytes left minus one
    logic [15:0]     raddr_reg;       // register address being saved
    logic [AW:0]     naddr_reg;       // memory address, top bit means full
    logic            active_reg;      // transfer in process
    logic            err_reg;         // transfer error seen
    logic            wren_reg;        // memory write enable
    logic            save_req_reg;    // nvm_save_request
    logic            resume_reg;      // last save paused on pseudo end
    logic            pause_reg;       // current save is ending on pseudo end
    logic            update_reg;      // active bank update pulse
    logic [7:0]      rdata_reg;       // register read data
    logic            host_wr;         // host write accepted
    logic            strobe_wr;       // host wrote strobe bit
    logic            start;           // save begins this cycle
    logic            ptr_ok;          // pointer inside buffer
    logic [7:0]      cur;             // buffer byte under pointer
    logic            push_valid;      // word offered to buffer
    logic [7:0]      push_byte;       // byte of that word
    logic            adv;             // word taken this cycle
    logic            fifo_empty;      // buffer holds nothing
    logic            wr_busy;         // writer frame open
    logic            drain_done;      // every word written, writer idle

    nvsq_strm_if #(.W(FW)) seq_s ();
    nvsq_strm_if #(.W(FW)) nvm_s ();

    // host is locked out while a transfer runs; only status reads stay useful
    assign host_wr   = REG_WR_I & ~active_reg; // R14
    assign strobe_wr = host_wr & (REG_ADDR_I == nvsq_pkg::ADDR_STROBE) &
                       REG_WDATA_I[nvsq_pkg::BIT_FLAG];
    assign start     = strobe_wr & save_req_reg & wren_reg & (state_reg == S_IDLE); // R4
    assign ptr_ok    = (ptr_reg < 5'(BUF_N));
    assign cur       = ptr_ok ? buf_mem[ptr_reg] : nvsq_pkg::OPC_END;
    assign adv       = push_valid & seq_s.ready;
    assign drain_done = (state_reg == S_DRAIN) & fifo_empty & ~wr_busy;

    // buffer segment: written by host only, outside a transfer
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int i = 0; i < BUF_N; i++) begin
                buf_mem[i] <= nvsq_pkg::BUF_RESET_VAL;
            end
        end else if (host_wr && is_buf(REG_ADDR_I)) begin // R1
            buf_mem[buf_idx(REG_ADDR_I)] <= REG_WDATA_I;
        end
    end

    // control bits; writes elsewhere fall through with no effect
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wren_reg     <= 1'b0;
            save_req_reg <= 1'b0;
        end else begin
            if (host_wr && REG_ADDR_I == nvsq_pkg::ADDR_WR_ENABLE) begin // R10
                wren_reg <= REG_WDATA_I[nvsq_pkg::BIT_FLAG];
            end
            if (host_wr && REG_ADDR_I == nvsq_pkg::ADDR_SAVE_REQ) begin
                save_req_reg <= REG_WDATA_I[nvsq_pkg::BIT_FLAG];
            end else if (drain_done) begin
                save_req_reg <= 1'b0;                     // R3
            end
        end
    end

    // strobe outside a save copies the buffer bank into the active bank
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            update_reg <= 1'b0;
        end else begin
            update_reg <= strobe_wr & ~start;             // R13
        end
    end

    // register read data, one cycle after the address
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rdata_reg <= 8'h00;
        end else if (REG_ADDR_I == nvsq_pkg::ADDR_STATUS) begin
            rdata_reg <= {7'h00, active_reg};             // R12
        end else if (active_reg) begin
            rdata_reg <= 8'h00;                           // only status during transfer
        end else if (is_buf(REG_ADDR_I)) begin
            rdata_reg <= buf_mem[buf_idx(REG_ADDR_I)];
        end else if (REG_ADDR_I == nvsq_pkg::ADDR_ERROR) begin
            rdata_reg <= {7'h00, err_reg};
        end else if (REG_ADDR_I == nvsq_pkg::ADDR_WR_ENABLE) begin
            rdata_reg <= {7'h00, wren_reg};
        end else if (REG_ADDR_I == nvsq_pkg::ADDR_SAVE_REQ) begin
            rdata_reg <= {7'h00, save_req_reg};
        end else begin
            rdata_reg <= 8'h00;                           // unmapped reads as zero
        end
    end

    // word offered to the buffer in each state
    always_comb begin
        push_valid = 1'b0;
        push_byte  = 8'h00;
        case (state_reg)
            S_CMD: begin
                if (ptr_ok && !naddr_reg[AW]) begin
                    if (cur == nvsq_pkg::OPC_END || cur == nvsq_pkg::OPC_STROBE ||
                        !cur[nvsq_pkg::BIT_CODE]) begin   // R11 R9 R7
                        push_valid = 1'b1;
                        push_byte  = cur;
                    end
                end
            end
            S_AHI, S_ALO: begin
                push_valid = ~naddr_reg[AW];
                push_byte  = cur;                         // R8
            end
            S_DAT: begin
                push_valid = ~naddr_reg[AW];
                push_byte  = CFG_DATA_I;                  // R6
            end
            default: begin
                push_valid = 1'b0;
                push_byte  = 8'h00;
            end
        endcase
    end

    assign seq_s.valid = push_valid;
    assign seq_s.data  = {naddr_reg[AW-1:0], push_byte};

    // sequencer state
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_reg <= S_IDLE;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (start) begin
                        state_reg <= S_CMD;
                    end
                end
                S_CMD: begin
                    if (!ptr_ok || naddr_reg[AW]) begin
                        state_reg <= S_DRAIN;             // ran off the buffer or memory
                    end else if (cur == nvsq_pkg::OPC_PSEUDO_END) begin
                        state_reg <= S_DRAIN;             // R2
                    end else if (cur == nvsq_pkg::OPC_END) begin
                        if (adv) begin
                            state_reg <= S_DRAIN;         // R11
                        end
                    end else if (cur == nvsq_pkg::OPC_STROBE) begin
                        state_reg <= S_CMD;               // R9
                    end else if (!cur[nvsq_pkg::BIT_CODE]) begin
                        if (adv) begin
                            state_reg <= S_AHI;           // R7
                        end
                    end else begin
                        state_reg <= S_DRAIN;             // unknown code
                    end
                end
                S_AHI: begin
                    if (naddr_reg[AW]) begin
                        state_reg <= S_DRAIN;
                    end else if (adv) begin
                        state_reg <= S_ALO;
                    end
                end
                S_ALO: begin
                    if (naddr_reg[AW]) begin
                        state_reg <= S_DRAIN;
                    end else if (adv) begin
                        state_reg <= S_RD;
                    end
                end
                S_RD: begin
                    state_reg <= S_DAT;                   // bank data valid next cycle
                end
                S_DAT: begin
                    if (naddr_reg[AW]) begin
                        state_reg <= S_DRAIN;
                    end else if (adv) begin
                        state_reg <= (cnt_reg == 7'h00) ? S_CMD : S_RD;
                    end
                end
                S_DRAIN: begin
                    if (drain_done) begin
                        state_reg <= S_IDLE;              // R3
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // buffer pointer, group count and register address
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ptr_reg   <= 5'h00;
            cnt_reg   <= 7'h00;
            raddr_reg <= 16'h0000;
        end else if (start) begin
            ptr_reg <= 5'h00;                             // each segment walks from slot 0
        end else begin
            if (adv && state_reg != S_DAT) begin
                ptr_reg <= ptr_reg + 5'h01;
            end
            if (adv && state_reg == S_CMD) begin
                cnt_reg <= cur[6:0];                      // R7
            end
            if (adv && state_reg == S_AHI) begin
                raddr_reg[15:8] <= cur;                   // R8
            end
            if (adv && state_reg == S_ALO) begin
                raddr_reg[7:0] <= cur;                    // R8
            end
            if (adv && state_reg == S_DAT) begin
                raddr_reg <= raddr_reg + 16'h0001;
                cnt_reg   <= cnt_reg - 7'h01;
            end
        end
    end

    // memory address: kept across a pseudo end, cleared on a fresh save
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            naddr_reg <= '0;
        end else if (start && !resume_reg) begin
            naddr_reg <= '0;
        end else if (adv) begin
            naddr_reg <= naddr_reg + 1'b1;                // R5
        end
    end

    // transfer status, error and pause bookkeeping
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            active_reg <= 1'b0;
            err_reg    <= 1'b0;
            pause_reg  <= 1'b0;
            resume_reg <= 1'b0;
        end else begin
            if (start) begin
                active_reg <= 1'b1;                       // R12
                err_reg    <= 1'b0;
                pause_reg  <= 1'b0;
            end else if (drain_done) begin
                active_reg <= 1'b0;                       // R12
                resume_reg <= pause_reg;                  // R5
            end
            if (state_reg == S_CMD && ptr_ok && !naddr_reg[AW] &&
                cur == nvsq_pkg::OPC_PSEUDO_END) begin
                pause_reg <= 1'b1;                        // R2
            end
            // a bad code, a missing end or a full memory marks the save as failed
            if ((state_reg == S_CMD && (!ptr_ok || (cur[nvsq_pkg::BIT_CODE] &&
                 cur != nvsq_pkg::OPC_END && cur != nvsq_pkg::OPC_STROBE &&
                 cur != nvsq_pkg::OPC_PSEUDO_END))) ||
                (state_reg != S_IDLE && state_reg != S_DRAIN && naddr_reg[AW])) begin
                err_reg <= 1'b1;
            end
        end
    end

    // register bank address for the value being saved
    assign CFG_ADDR_O = raddr_reg;

    // two-entry buffer between the walker and the serial writer
    nvsq_buf2 #(.W(FW)) u_buf (
        .clk_i   (MCLK_I),
        .rstn_i  (RSTN_I),
        .in_s    (seq_s),
        .out_s   (nvm_s),
        .empty_o (fifo_empty)
    );

    // serial writer into the configuration memory
    nvsq_nvm_wr u_wr (
        .clk_i  (MCLK_I),
        .rstn_i (RSTN_I),
        .in_s   (nvm_s),
        .cs_o   (NVM_CS_O),
        .sck_o  (NVM_SCK_O),
        .sdo_o  (NVM_SDO_O),
        .busy_o (wr_busy)
    );

    assign REG_RDATA_O     = rdata_reg;
    assign HOST_PORT_EN_O  = ~active_reg;                 // R3
    assign STATUS_ACTIVE_O = active_reg;
    assign UPDATE_O        = update_reg;
endmodule

// ===== bench/nvsq_nvm_model.sv
// behavioural configuration memory on the sequencer's serial pins
// assumes msb-first frames of 9 address bits then 8 data bits
`timescale 1ns/10ps
module nvsq_nvm_model (
    // serial pins
    input wire logic cs_i,
    input wire logic sck_i,
    input wire logic sdo_i
);
    logic [7:0]  mem [0:511]; // stored bytes
    logic [16:0] sh;          // frame shifter
    int          n_bits = 0;  // rising clocks in the open frame
    int          n_frames = 0;
    // shift on rising clock inside a frame only
    always @(posedge sck_i) begin
        if (cs_i) begin
            sh <= {sh[15:0], sdo_i};
            n_bits <= n_bits + 1;
        end
    end
    // a full frame is written to the byte at its address when select drops;
    // select settling out of reset is no frame
    always @(negedge cs_i) begin
        if (n_bits == 17) begin
            mem[sh[16:8]] = sh[7:0];
            n_frames++;
        end
        n_bits = 0;
    end
endmodule

// ===== bench/nvsq_top_asserts.sv
// port checker for the profile save sequencer
// assumes one clock and the async active-low reset
`timescale 1ns/10ps
module nvsq_top_asserts (
    // watched ports
    input wire logic        MCLK_I,
    input wire logic        RSTN_I,
    input wire logic        REG_WR_I,
    input wire logic [15:0] REG_ADDR_I,
    input wire logic [7:0]  REG_WDATA_I,
    input wire logic [7:0]  REG_RDATA_O,
    input wire logic        HOST_PORT_EN_O,
    input wire logic        UPDATE_O,
    input wire logic        STATUS_ACTIVE_O,
    input wire logic        NVM_CS_O,
    input wire logic        NVM_SCK_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    AST_START: assert property (
        REG_WR_I && REG_ADDR_I == 16'h0232 && REG_WDATA_I[0] && !STATUS_ACTIVE_O
        |=> STATUS_ACTIVE_O != UPDATE_O) else $error("strobe gave no start or update");
    AST_RD_LOCK: assert property (
        STATUS_ACTIVE_O && $past(STATUS_ACTIVE_O) && $past(REG_ADDR_I) != 16'h0B00
        |-> REG_RDATA_O == 8'h00) else $error("register read open during save");
    AST_STAT_RD: assert property (
        $past(STATUS_ACTIVE_O) && $past(REG_ADDR_I) == 16'h0B00 |-> REG_RDATA_O[0])
        else $error("status read misses active");
    AST_HOST_EN: assert property (
        HOST_PORT_EN_O == !STATUS_ACTIVE_O) else $error("host port not inverse of active");
    AST_UPD_CAUSE: assert property (
        UPDATE_O |-> !STATUS_ACTIVE_O && $past(REG_WR_I) && $past(REG_ADDR_I) == 16'h0232)
        else $error("update without strobe");
    AST_CS_IDLE: assert property (
        !STATUS_ACTIVE_O |-> !NVM_CS_O) else $error("frame outside save");
    AST_SCK_IDLE: assert property (
        !NVM_CS_O |-> !NVM_SCK_O) else $error("serial clock outside frame");
    AST_FRAME: assert property (
        $rose(NVM_CS_O) |-> NVM_CS_O[*8] ##26 NVM_CS_O ##1 !NVM_CS_O)
        else $error("frame length wrong");
endmodule
bind nvsq_top nvsq_top_asserts nvsq_top_asserts_i (.MCLK_I, .RSTN_I, .REG_WR_I,
    .REG_ADDR_I, .REG_WDATA_I, .REG_RDATA_O, .HOST_PORT_EN_O, .UPDATE_O,
    .STATUS_ACTIVE_O, .NVM_CS_O, .NVM_SCK_O);

// ===== bench/test_nvm_profile_save_sequencer.sv
// self-checking bench for the profile save sequencer
// assumes the memory model and the bound checker
`timescale 1ns/10ps
module test_nvm_profile_save_sequencer;
    logic        mclk = 0, rstn = 0, reg_wr = 0, host_en, upd, act, cs, sck, sdo;
    logic [15:0] reg_addr = 0, cfg_addr, base;
    logic [7:0]  reg_wdata = 0, reg_rdata, key, cfg_data;
    int          n_mismatch = 0;
    int          n_tests = 0;
    always #25 mclk = ~mclk;
    // register bank contents are a keyed image of the address
    assign cfg_data = cfg_addr[7:0] ^ key;
    nvsq_top nvsq_top_i (.MCLK_I(mclk), .RSTN_I(rstn), .REG_WR_I(reg_wr),
        .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_RDATA_O(reg_rdata),
        .HOST_PORT_EN_O(host_en), .CFG_ADDR_O(cfg_addr), .CFG_DATA_I(cfg_data),
        .UPDATE_O(upd), .STATUS_ACTIVE_O(act), .NVM_CS_O(cs), .NVM_SCK_O(sck),
        .NVM_SDO_O(sdo));
    nvsq_nvm_model nvsq_nvm_model_i (.cs_i(cs), .sck_i(sck), .sdo_i(sdo));
    function automatic logic [7:0] val(input logic [15:0] a);
        return a[7:0] ^ key;
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        @(posedge mclk);
        #1 chk("rdata", {8'h00, reg_rdata}, {8'h00, e});
    endtask
    // bounded wait for the save to finish
    task automatic idle();
        for (int i = 0; i < 3000; i++) begin
            @(posedge mclk);
            #1;
            if (act === 1'b0) break;
        end
        chk("active", {15'h0, act}, 16'h0);
    endtask
    task automatic frames(input int at, input logic [7:0] e[$]);
        foreach (e[i]) chk("nvm", {8'h00, nvsq_nvm_model_i.mem[at+i]}, {8'h00, e[i]});
        chk("count", 16'(nvsq_nvm_model_i.n_frames), 16'(at + e.size()));
    endtask
    task automatic end_of_test();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #2000000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        void'($urandom(47));
        key = 8'($urandom);
        base = 16'($urandom % 200);
        repeat (8) @(posedge mclk);
        rstn <= 1;
        rd(nvsq_pkg::END_OPCODE_SLOT, 8'hFF);
        wr(16'h0A17, 8'h12);
        rd(16'h0A17, 8'h00);
        wr(16'h0001, 8'h5A);
        rd(16'h0001, 8'h00);
        $display("test reset done");
        wr(nvsq_pkg::GROUP1_BYTE_COUNT, 8'h01);
        wr(nvsq_pkg::GROUP1_ADDR_HIGH, base[15:8]);
        wr(nvsq_pkg::GROUP1_ADDR_LOW, base[7:0]);
        wr(nvsq_pkg::GROUP2_BYTE_COUNT, nvsq_pkg::OPC_STROBE);
        wr(nvsq_pkg::GROUP2_ADDR_HIGH, nvsq_pkg::OPC_PSEUDO_END);
        wr(nvsq_pkg::ADDR_WR_ENABLE, 8'h01);
        wr(nvsq_pkg::ADDR_SAVE_REQ, 8'h01);
        wr(nvsq_pkg::ADDR_STROBE, 8'h01);
        rd(nvsq_pkg::ADDR_STATUS, 8'h01);
        wr(nvsq_pkg::GROUP1_BYTE_COUNT, 8'h05);
        idle();
        rd(nvsq_pkg::ADDR_SAVE_REQ, 8'h00);
        rd(nvsq_pkg::GROUP1_BYTE_COUNT, 8'h01);
        frames(0, '{8'h01, base[15:8], base[7:0], val(base), val(base + 1), 8'h80});
        $display("test pause done");
        wr(nvsq_pkg::GROUP1_BYTE_COUNT, 8'h00);
        wr(nvsq_pkg::GROUP2_BYTE_COUNT, nvsq_pkg::OPC_END);
        wr(nvsq_pkg::ADDR_SAVE_REQ, 8'h01);
        wr(nvsq_pkg::ADDR_STROBE, 8'h01);
        idle();
        frames(6, '{8'h00, base[15:8], base[7:0], val(base), 8'hFF});
        rd(nvsq_pkg::ADDR_ERROR, 8'h00);
        $display("test resume done");
        wr(nvsq_pkg::ADDR_WR_ENABLE, 8'h00);
        wr(nvsq_pkg::ADDR_STROBE, 8'h01);
        #1 chk("update", {15'h0, upd}, 16'h1);
        $display("test update done");
        end_of_test();
    end
endmodule
